// ### rtl/clk_ctl_if.sv
// carrier between power control, oscillator sequencer and clock divider
`timescale 1ns/1ps
interface clk_ctl_if;
	logic [1:0] enable_code; // oscillator enable field
	logic suspend; // suspend requested
	logic stopped; // stop mode active
	logic osc_running; // oscillator delivering clock
	logic freq_ready; // settled at programmed frequency
	logic [2:0] divide_select; // core clock ratio code
	logic core_tick; // one-cycle core clock enable

	modport ctl (
		output enable_code, suspend, stopped, divide_select,
		input osc_running, freq_ready, core_tick
	);
	modport osc (
		input enable_code, suspend, stopped,
		output osc_running, freq_ready
	);
	modport div (
		input osc_running, divide_select,
		output core_tick
	);
endinterface : clk_ctl_if

// ### rtl/core_clock_divider.sv
// divides the oscillator clock to the core clock enable pulse
`timescale 1ns/1ps
module core_clock_divider (
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// control carrier
	clk_ctl_if.div ctl
);
	typedef struct packed {
		logic [6:0] count; // cycles since last tick
		logic [7:0] gap; // check counter for tick spacing
	} div_t;

	div_t cur; // registered state
	div_t next_cur; // next state
	logic [6:0] last; // terminal count for current code

	assign last = osc_pkg::div_last(ctl.divide_select);

	// count up to the terminal value, tick on it
	always_comb begin
		next_cur = cur;
		if (!ctl.osc_running) begin
			next_cur.count = 7'h00;
		end else if (cur.count >= last) begin
			next_cur.count = 7'h00;
		end else begin
			next_cur.count = cur.count + 7'h01;
		end
		// gap counter restarts at each tick
		if (ctl.core_tick || !ctl.osc_running) begin
			next_cur.gap = 8'h01;
		end else if (cur.gap != 8'hFF) begin
			next_cur.gap = cur.gap + 8'h01;
		end
	end

	// state register
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cur <= '{count: 7'h00, gap: 8'h01};
		end else begin
			cur <= next_cur;
		end
	end

	// tick on the terminal count while oscillating
	assign ctl.core_tick = ctl.osc_running && (cur.count >= last);

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	// spacing between ticks equals the selected ratio
	tick_spacing_a: assert property (ctl.core_tick && $past(ctl.core_tick) == 1'b0
		&& $stable(ctl.divide_select) && $past(ctl.osc_running)
		&& cur.gap != 8'h01 |-> cur.gap == 8'({1'b0, last} + 8'h01))
		else $error("core tick spacing differs from ratio");
	// code 110 ticks every second cycle
	div_two_a: assert property (ctl.divide_select == osc_pkg::DIV_2 && ctl.core_tick
		&& $stable(ctl.divide_select) ##1 ctl.osc_running && $stable(ctl.divide_select)
		|-> !ctl.core_tick)
		else $error("code 110 not dividing by two");
endmodule : core_clock_divider

// ### rtl/osc_pkg.sv
// constants for the oscillator and power control files, and the divider function used by the clock divider
package osc_pkg;
	// register addresses on the special function register bus
	localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
	localparam logic [7:0] ADDR_OSC_CONTROL = 8'hA1;
	// power control field positions
	localparam int PWR_IDLE_BIT = 0;
	localparam int PWR_STOP_BIT = 1;
	localparam int PWR_FLAGS_LSB = 2;
	localparam int PWR_FLAGS_MSB = 7;
	// oscillator control field positions
	localparam int OSC_DIV_LSB = 0;
	localparam int OSC_DIV_MSB = 2;
	localparam int OSC_RSVD_BIT = 3;
	localparam int OSC_READY_BIT = 4;
	localparam int OSC_SUSPEND_BIT = 5;
	localparam int OSC_EN_LSB = 6;
	localparam int OSC_EN_MSB = 7;
	// reset values
	localparam logic [5:0] FLAGS_RESET = 6'h00;
	localparam logic [1:0] ENABLE_RESET = 2'h3;
	localparam logic [2:0] DIV_RESET = 3'h0;
	localparam logic [7:0] READ_IDLE = 8'h00;
	// enable field codes
	localparam logic [1:0] ENABLE_OFF = 2'h0;
	localparam logic [1:0] ENABLE_ON = 2'h3;
	// divider select codes
	localparam logic [2:0] DIV_128 = 3'h0;
	localparam logic [2:0] DIV_64 = 3'h1;
	localparam logic [2:0] DIV_32 = 3'h2;
	localparam logic [2:0] DIV_16 = 3'h3;
	localparam logic [2:0] DIV_8 = 3'h4;
	localparam logic [2:0] DIV_4 = 3'h5;
	localparam logic [2:0] DIV_2 = 3'h6;
	localparam logic [2:0] DIV_1 = 3'h7;
	// timing: oscillator settling before the ready flag rises
	localparam int CLK_PERIOD_NS = 20;
	localparam int SETTLE_NS = 1000;
	localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [5:0] SETTLE_LAST = 6'(SETTLE_CYCLES - 1);

	// terminal count of the core clock divider for a select code
	function automatic logic [6:0] div_last(input logic [2:0] sel);
		logic [6:0] r;
		r = 7'h00;
		unique case (sel)
			DIV_128: r = 7'h7F;
			DIV_64: r = 7'h3F;
			DIV_32: r = 7'h1F;
			DIV_16: r = 7'h0F;
			DIV_8: r = 7'h07;
			DIV_4: r = 7'h03;
			DIV_2: r = 7'h01;
			DIV_1: r = 7'h00;
		endcase
		return r;
	endfunction : div_last
endpackage : osc_pkg

// ### rtl/osc_power_ctl.sv
// internal oscillator and power mode control behind two sfr registers
//
// How it works
// - enable code 00 off, 11 runs
// - suspend bit 5 write suspends oscillator
// - wake event restarts suspended oscillator
// - ready flag bit 4 shows settled
// - bit 3 reads zero, written zero
// - select codes divide 128 down to 1
// - stop bit halts cpu and oscillator
// - idle bit gates only cpu clock
// - bits 7:2 are plain general flags
`timescale 1ns/1ps
module osc_power_ctl (
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// special function register access
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_we,
	input wire logic sfr_re,
	output logic [7:0] sfr_rdata,
	// wake and interrupt sources
	input wire logic wake_pin,
	input wire logic irq_pending,
	// clock outputs
	output logic osc_enable,
	output logic core_clock_en,
	output logic cpu_clk_en,
	output logic periph_clk_en
);
	typedef struct packed {
		logic [5:0] general_flags; // software flags
		logic [1:0] osc_enable_field; // oscillator enable code
		logic suspend; // suspend bit
		logic [2:0] core_clock_divide_select; // divider code
		logic idle; // cpu clock gated
		logic stopped; // stop mode
		logic [7:0] rdata; // read data register
		logic [2:0] wake_sync; // wake pin synchroniser
		logic wake_level; // accepted wake level
	} ctl_t;

	ctl_t cur; // registered state
	ctl_t next_cur; // next state
	logic sel_pwr; // power control addressed
	logic sel_osc; // oscillator control addressed
	logic wake_evt; // accepted wake edge
	logic [7:0] pwr_view; // power control read value
	logic [7:0] osc_view; // oscillator control read value

	clk_ctl_if link ();

	// oscillator sequencer
	osc_sequencer u_seq (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.ctl(link)
	);

	// core clock divider
	core_clock_divider u_div (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.ctl(link)
	);

	// register fields drive the carrier
	assign link.enable_code = cur.osc_enable_field;
	assign link.suspend = cur.suspend;
	assign link.stopped = cur.stopped;
	assign link.divide_select = cur.core_clock_divide_select;

	// address decode
	assign sel_pwr = (sfr_addr == osc_pkg::ADDR_POWER_CONTROL);
	assign sel_osc = (sfr_addr == osc_pkg::ADDR_OSC_CONTROL);

	// wake edge once second and third stage agree high after low
	assign wake_evt = (cur.wake_sync[1] == cur.wake_sync[2]) && cur.wake_sync[2]
		&& !cur.wake_level;

	// read views: stop and idle read 0, reserved bit reads 0
	always_comb begin
		pwr_view = 8'h00;
		pwr_view[osc_pkg::PWR_FLAGS_MSB:osc_pkg::PWR_FLAGS_LSB] =
			cur.general_flags;
		// mode bits are actions, never stored for readback
		pwr_view[osc_pkg::PWR_STOP_BIT] = 1'b0;
		pwr_view[osc_pkg::PWR_IDLE_BIT] = 1'b0;
	end

	// oscillator control read view
	always_comb begin
		osc_view = 8'h00;
		osc_view[osc_pkg::OSC_EN_MSB:osc_pkg::OSC_EN_LSB] = cur.osc_enable_field;
		osc_view[osc_pkg::OSC_SUSPEND_BIT] = cur.suspend;
		osc_view[osc_pkg::OSC_READY_BIT] = link.freq_ready;
		osc_view[osc_pkg::OSC_RSVD_BIT] = 1'b0;
		osc_view[osc_pkg::OSC_DIV_MSB:osc_pkg::OSC_DIV_LSB] =
			cur.core_clock_divide_select;
	end

	// next state: synchroniser, register writes, mode changes
	always_comb begin
		next_cur = cur;
		// synchroniser shifts
		next_cur.wake_sync = {cur.wake_sync[1:0], wake_pin};
		if (cur.wake_sync[1] == cur.wake_sync[2]) begin
			next_cur.wake_level = cur.wake_sync[2];
		end
		// wake restarts a suspended oscillator
		if (wake_evt) begin
			next_cur.suspend = 1'b0;
		end
		// a pending interrupt ends idle
		if (irq_pending) begin
			next_cur.idle = 1'b0;
		end
		// register writes; a set written now wins over a wake clear
		if (sfr_we && sel_pwr) begin
			next_cur.general_flags =
				sfr_wdata[osc_pkg::PWR_FLAGS_MSB:osc_pkg::PWR_FLAGS_LSB];
			if (sfr_wdata[osc_pkg::PWR_STOP_BIT]) begin
				next_cur.stopped = 1'b1;
			end
			// idle set wins over a pending interrupt in the same cycle
			if (sfr_wdata[osc_pkg::PWR_IDLE_BIT]) begin
				next_cur.idle = 1'b1;
			end
		end
		if (sfr_we && sel_osc) begin
			// reserved bit 3 is not stored
			next_cur.osc_enable_field =
				sfr_wdata[osc_pkg::OSC_EN_MSB:osc_pkg::OSC_EN_LSB];
			if (sfr_wdata[osc_pkg::OSC_SUSPEND_BIT]) begin
				next_cur.suspend = 1'b1;
			end else if (!wake_evt) begin
				next_cur.suspend = cur.suspend;
			end
			next_cur.core_clock_divide_select =
				sfr_wdata[osc_pkg::OSC_DIV_MSB:osc_pkg::OSC_DIV_LSB];
		end
		// read data register, unmapped reads return zero
		if (sfr_re) begin
			if (sel_pwr) begin
				next_cur.rdata = pwr_view;
			end else if (sel_osc) begin
				next_cur.rdata = osc_view;
			end else begin
				next_cur.rdata = osc_pkg::READ_IDLE;
			end
		end
	end

	// state register; stop mode ends only through reset
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cur <= '{
				general_flags: osc_pkg::FLAGS_RESET,
				osc_enable_field: osc_pkg::ENABLE_RESET,
				suspend: 1'b0,
				core_clock_divide_select: osc_pkg::DIV_RESET,
				idle: 1'b0,
				stopped: 1'b0,
				rdata: osc_pkg::READ_IDLE,
				wake_sync: 3'h0,
				wake_level: 1'b0
			};
		end else begin
			cur <= next_cur;
		end
	end

	// outputs
	assign sfr_rdata = cur.rdata;
	assign osc_enable = link.osc_running;
	assign core_clock_en = link.core_tick;
	// cpu loses its clock in idle or stop, peripherals only in stop
	assign cpu_clk_en = link.core_tick && !cur.idle && !cur.stopped;
	assign periph_clk_en = link.core_tick && !cur.stopped;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	// write to the power control register in one cycle
	sequence pwr_write_s;
		sfr_we && sel_pwr;
	endsequence
	// read of the power control register, data one cycle later
	sequence pwr_read_s;
		sfr_re && sel_pwr && !sfr_we;
	endsequence
	// write to the oscillator control register in one cycle
	sequence osc_write_s;
		sfr_we && sel_osc;
	endsequence
	// read of the oscillator control register
	sequence osc_read_s;
		sfr_re && sel_osc;
	endsequence
	// wake pin low through every synchroniser stage
	sequence pin_low_s;
		!wake_pin [*3];
	endsequence
	// accepted wake while suspended, no register write beside it
	sequence clean_wake_s;
		wake_evt && cur.suspend && !(sfr_we && (sel_osc || sel_pwr));
	endsequence

	// power control register checks
	// stop and idle always read zero
	mode_bits_zero_a: assert property (pwr_read_s |=>
		sfr_rdata[osc_pkg::PWR_STOP_BIT] == 1'b0
		&& sfr_rdata[osc_pkg::PWR_IDLE_BIT] == 1'b0)
		else $error("stop or idle bit read as one");
	// general flags read back what was written
	flags_readback_a: assert property (pwr_read_s |=>
		sfr_rdata[osc_pkg::PWR_FLAGS_MSB:osc_pkg::PWR_FLAGS_LSB]
		== $past(cur.general_flags))
		else $error("general flags readback mismatch");
	// a flags write is kept whole
	flags_write_a: assert property (pwr_write_s |=>
		cur.general_flags
		== $past(sfr_wdata[osc_pkg::PWR_FLAGS_MSB:osc_pkg::PWR_FLAGS_LSB]))
		else $error("general flags not stored");

	// oscillator control register checks
	// reserved bit reads zero
	reserved_zero_a: assert property (osc_read_s |=>
		sfr_rdata[osc_pkg::OSC_RSVD_BIT] == 1'b0)
		else $error("reserved bit read as one");
	// any code but 11 leaves the oscillator halted next cycle
	enable_code_a: assert property (cur.osc_enable_field != osc_pkg::ENABLE_ON
		|=> !osc_enable)
		else $error("oscillator running without enable code 11");
	// a divider write is taken whole
	div_write_a: assert property (osc_write_s |=>
		link.divide_select == $past(sfr_wdata[osc_pkg::OSC_DIV_MSB:osc_pkg::OSC_DIV_LSB]))
		else $error("divider select not stored");

	// suspend and wake checks
	// writing suspend stops the oscillator within two cycles
	suspend_stops_a: assert property (osc_write_s
		##0 sfr_wdata[osc_pkg::OSC_SUSPEND_BIT] ##1 !wake_evt
		|-> ##[1:2] !osc_enable)
		else $error("oscillator still running after suspend");
	// a suspend held two cycles keeps the oscillator off
	suspend_off_a: assert property (cur.suspend && $past(cur.suspend)
		|-> !osc_enable)
		else $error("oscillator running while suspended");
	// writing zero leaves suspend set until a wake
	suspend_holds_a: assert property (cur.suspend && !wake_evt |=> cur.suspend)
		else $error("suspend cleared without a wake");
	// a wake needs the pin high in both late stages
	wake_sync_a: assert property (pin_low_s |=> !wake_evt)
		else $error("wake accepted without a synchronised edge");
	// accepted wake clears a suspend without a new one written
	wake_clears_a: assert property (wake_evt && cur.suspend
		&& !(sfr_we && sel_osc && sfr_wdata[osc_pkg::OSC_SUSPEND_BIT])
		|=> !cur.suspend)
		else $error("wake did not clear suspend");
	// a clean wake with enable 11 restarts the oscillator
	wake_restart_a: assert property (clean_wake_s
		##0 (cur.osc_enable_field == osc_pkg::ENABLE_ON && !cur.stopped)
		|-> ##2 osc_enable)
		else $error("oscillator did not restart after wake");

	// stop and idle checks
	// stop halts the cpu clock and the oscillator
	stop_halts_a: assert property (pwr_write_s
		##0 sfr_wdata[osc_pkg::PWR_STOP_BIT] |=> !cpu_clk_en ##1 !osc_enable)
		else $error("stop mode did not halt");
	// stop mode stays until reset and gates every clock
	stop_sticky_a: assert property (cur.stopped
		|=> cur.stopped && !cpu_clk_en && !periph_clk_en)
		else $error("stop mode left or clocks still running");
	// idle keeps peripherals clocked but not the cpu
	idle_gates_cpu_a: assert property (cur.idle && link.core_tick && !cur.stopped
		|-> periph_clk_en && !cpu_clk_en)
		else $error("idle gating wrong");
	// an idle write takes effect next cycle
	idle_set_a: assert property (pwr_write_s ##0 sfr_wdata[osc_pkg::PWR_IDLE_BIT]
		|=> cur.idle)
		else $error("idle write not taken");
	// a pending interrupt ends idle unless idle is written again
	idle_wake_a: assert property (irq_pending && cur.idle
		&& !(sfr_we && sel_pwr && sfr_wdata[osc_pkg::PWR_IDLE_BIT])
		|=> !cur.idle)
		else $error("interrupt did not end idle");

	// ready flag and read data checks
	// ready flag readback follows the sequencer
	ready_readback_a: assert property (osc_read_s |=>
		sfr_rdata[osc_pkg::OSC_READY_BIT] == $past(link.freq_ready))
		else $error("ready flag readback mismatch");
	// ready only while the oscillator runs
	ready_running_a: assert property (link.freq_ready |-> osc_enable)
		else $error("ready flag set with oscillator off");
	// read data stands until the next read
	rdata_hold_a: assert property (!sfr_re |=> $stable(sfr_rdata))
		else $error("read data changed without a read");
endmodule : osc_power_ctl

// ### rtl/osc_sequencer.sv
// oscillator power sequencer: off, settling, running, halted
`timescale 1ns/1ps
module osc_sequencer (
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// control carrier
	clk_ctl_if.osc ctl
);
	typedef enum logic [3:0] {
		ST_OFF = 4'h1,
		ST_SETTLE = 4'h2,
		ST_RUN = 4'h4,
		ST_HALT = 4'h8
	} osc_state_t;

	typedef struct packed {
		osc_state_t state; // sequencer state
		logic [5:0] settle; // settle cycle counter
	} seq_t;

	seq_t cur; // registered state
	seq_t next_cur; // next state
	logic want_run; // conditions allow oscillation

	// oscillator runs only with code 11, no suspend, no stop
	assign want_run = (ctl.enable_code == osc_pkg::ENABLE_ON) && !ctl.suspend
		&& !ctl.stopped;

	// next state logic
	always_comb begin
		next_cur = cur;
		unique case (cur.state)
			ST_OFF, ST_HALT: begin
				// restart from a fresh settle
				next_cur.settle = 6'h00;
				if (want_run) begin
					next_cur.state = ST_SETTLE;
				end else if (ctl.enable_code == osc_pkg::ENABLE_OFF) begin
					next_cur.state = ST_OFF;
				end else begin
					next_cur.state = ST_HALT;
				end
			end
			ST_SETTLE: begin
				// count settle time, then report ready
				if (!want_run) begin
					next_cur.state = ST_HALT;
				end else if (cur.settle == osc_pkg::SETTLE_LAST) begin
					next_cur.state = ST_RUN;
				end else begin
					next_cur.settle = cur.settle + 6'h01;
				end
			end
			ST_RUN: begin
				// leave on any disable, suspend or stop
				if (!want_run) begin
					next_cur.state = ST_HALT;
				end
			end
			default: begin
				next_cur.state = ST_OFF;
			end
		endcase
	end

	// state register
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cur <= '{state: ST_SETTLE, settle: 6'h00};
		end else begin
			cur <= next_cur;
		end
	end

	// outputs straight from the state
	assign ctl.osc_running = cur.state inside {ST_SETTLE, ST_RUN};
	assign ctl.freq_ready = (cur.state == ST_RUN);

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	// ready rises only after a full settle count
	ready_settle_a: assert property ($rose(ctl.freq_ready) |->
		$past(cur.settle) == osc_pkg::SETTLE_LAST)
		else $error("ready rose before settle time");
	// code 00 stops the oscillator next cycle
	off_code_a: assert property (ctl.enable_code == osc_pkg::ENABLE_OFF |=>
		!ctl.osc_running)
		else $error("oscillator running with enable code 00");
endmodule : osc_sequencer

// ### verification/internal_osc_power_control_tb_top.sv
// self-checking bench for the oscillator and power control registers
`timescale 1ns/1ps
module internal_osc_power_control_tb_top;
	// clock and reset
	logic mclk;
	logic sys_rst;
	// register access
	logic [7:0] sfr_addr;
	logic [7:0] sfr_wdata;
	logic sfr_we;
	logic sfr_re;
	logic [7:0] sfr_rdata;
	// wake and interrupt
	logic wake_pin;
	logic irq_pending;
	// clock outputs
	logic osc_enable;
	logic core_clock_en;
	logic cpu_clk_en;
	logic periph_clk_en;
	// bookkeeping
	int failures;
	int total_checks;
	int n; // measured divider period
	int cpu_n; // cpu enable pulses seen
	int per_n; // peripheral enable pulses seen
	logic [2:0] code; // divider code under test
	logic [1:0] en; // enable code under test

	// block under test
	osc_power_ctl dut (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.sfr_addr(sfr_addr),
		.sfr_wdata(sfr_wdata),
		.sfr_we(sfr_we),
		.sfr_re(sfr_re),
		.sfr_rdata(sfr_rdata),
		.wake_pin(wake_pin),
		.irq_pending(irq_pending),
		.osc_enable(osc_enable),
		.core_clock_en(core_clock_en),
		.cpu_clk_en(cpu_clk_en),
		.periph_clk_en(periph_clk_en)
	);

	// 50 MHz clock
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	// verdict and end of run
	task automatic end_sim;
		if (failures == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_sim

	// one clock, inputs move just after the edge
	task automatic step;
		@(posedge mclk);
		#1;
	endtask : step

	// compare one byte and report a mismatch
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// single-byte register write, strobe held one edge
	task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_we = 1'b1;
		step();
		sfr_we = 1'b0;
		step();
	endtask : sfr_write

	// single-byte register read with expected value
	task automatic sfr_read(input logic [7:0] a, input logic [7:0] exp);
		sfr_addr = a;
		sfr_re = 1'b1;
		step();
		sfr_re = 1'b0;
		chk(sfr_rdata, exp);
		step();
	endtask : sfr_read

	// bounded wait for the oscillator state; a miss ends the run
	task automatic wait_osc(input logic lvl);
		int i;
		for (i = 0; i < 20 && osc_enable !== lvl; i++) begin
			step();
		end
		if (osc_enable !== lvl) begin
			chk({7'h00, osc_enable}, {7'h00, lvl});
			end_sim();
		end
		total_checks++;
	endtask : wait_osc

	// cycles between two core clock pulses
	task automatic measure(output int p);
		int i;
		for (i = 0; i < 300 && core_clock_en !== 1'b1; i++) begin
			step();
		end
		if (core_clock_en !== 1'b1) begin
			chk({7'h00, core_clock_en}, 8'h01);
			end_sim();
		end
		step();
		p = 1;
		while (core_clock_en !== 1'b1 && p < 300) begin
			step();
			p++;
		end
		if (core_clock_en !== 1'b1) begin
			chk({7'h00, core_clock_en}, 8'h01);
			end_sim();
		end
	endtask : measure

	// count cpu and peripheral enable pulses over a window
	task automatic count_en(input int cyc, output int c, output int p);
		int i;
		c = 0;
		p = 0;
		for (i = 0; i < cyc; i++) begin
			if (cpu_clk_en === 1'b1) c++;
			if (periph_clk_en === 1'b1) p++;
			step();
		end
	endtask : count_en

	// expected division ratio for a select code
	function automatic int ratio(input logic [2:0] c);
		if (c == 3'h7) return 1;
		if (c == 3'h6) return 2;
		return 128 >> c;
	endfunction : ratio

	// main sequence
	initial begin
		failures = 0;
		total_checks = 0;
		sys_rst = 1'b1;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		sfr_we = 1'b0;
		sfr_re = 1'b0;
		wake_pin = 1'b0;
		irq_pending = 1'b0;
		repeat (16) @(posedge mclk);
		#1;
		sys_rst = 1'b0;
		// reset values, oscillator still settling
		sfr_read(8'h87, 8'h00);
		sfr_read(8'hA1, 8'hC0);
		wait_osc(1'b1);
		repeat (60) step();
		sfr_read(8'hA1, 8'hD0);
		// unmapped place reads zero, write there changes nothing
		sfr_read(8'h20, 8'h00);
		sfr_write(8'h20, 8'hFF);
		sfr_read(8'h87, 8'h00);
		sfr_read(8'hA1, 8'hD0);
		// every divider code, reserved bit 3 always written zero
		for (int k = 0; k < 8; k++) begin
			code = 3'(k);
			sfr_write(8'hA1, {5'b11000, code});
			measure(n);
			measure(n);
			chk(8'(n), 8'(ratio(code)));
			sfr_read(8'hA1, {5'b11010, code});
		end
		// general flags, mode bits read zero
		sfr_write(8'h87, 8'hFC);
		sfr_read(8'h87, 8'hFC);
		sfr_write(8'h87, 8'h55);
		sfr_read(8'h87, 8'h54);
		// idle: cpu gated, peripherals keep ticking at divide by 1
		count_en(20, cpu_n, per_n);
		chk(8'(cpu_n), 8'h00);
		chk(8'(per_n), 8'h14);
		irq_pending = 1'b1;
		repeat (3) step();
		irq_pending = 1'b0;
		count_en(10, cpu_n, per_n);
		chk(8'(cpu_n), 8'h0A);
		// enable codes 00, 01, 10 halt; 11 runs and settles again
		for (int k = 0; k < 3; k++) begin
			en = 2'(k);
			sfr_write(8'hA1, {en, 6'h07});
			wait_osc(1'b0);
			sfr_read(8'hA1, {en, 6'h07});
			sfr_write(8'hA1, 8'hC7);
			wait_osc(1'b1);
			repeat (55) step();
			sfr_read(8'hA1, 8'hD7);
		end
		// suspend holds until a wake edge
		sfr_write(8'hA1, 8'hE7);
		wait_osc(1'b0);
		repeat (10) step();
		chk({7'h00, osc_enable}, 8'h00);
		sfr_read(8'hA1, 8'hE7);
		wake_pin = 1'b1;
		wait_osc(1'b1);
		wake_pin = 1'b0;
		sfr_read(8'hA1, 8'hC7);
		repeat (55) step();
		sfr_read(8'hA1, 8'hD7);
		// stop halts oscillator and every clock, reads zero
		sfr_write(8'h87, 8'h02);
		wait_osc(1'b0);
		sfr_read(8'h87, 8'h00);
		count_en(20, cpu_n, per_n);
		chk(8'(cpu_n + per_n), 8'h00);
		end_sim();
	end
endmodule : internal_osc_power_control_tb_top
